// [src/sca_dev.sv]
`timescale 1ns/1ns
// Summary of operation
// - SDA stable while SCL high
// - SDA fall with SCL high starts
// - SDA rise with SCL high stops
// - Eight bits MSB first, then ack
// - Acknowledger pulls SDA low whole pulse
// - Addressed device acknowledges every byte
// - Master may stop on missing ack
// - Master may skip ack check
// - Start, chip, subaddress, data, stop
// - Address 88 open, 8A tied high
// - Subaddress bit four enables increment
// - No increment: all data one location
// - Increment loops; upper eight discarded
// - Subaddress 0..5 select outputs 1..6
// - Master sends bytes for unused slots
// - Low three bits: 1 dB steps
// - High five bits: 8 dB steps, mute
module sca_dev
    import sca_pkg::*;
#(
    parameter int NUM_OUT = SCA_NUM_OUT
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic addr_sel,
    sca_bus_if.dev bus,
    output logic [NUM_OUT-1:0][SCA_ATT_W-1:0] att_db,
    output logic [NUM_OUT-1:0] mute,
    output logic update
);

    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_SUB, ST_DATA, ST_IGNORE} sca_dev_state_type;

    ////////////////////////////////////////////////////////////////////////////
    // Start and stop edges, clocked by SDA itself

    logic start_tog;
    logic stop_tog;

    always_ff @(negedge bus.sda or negedge rst_n) begin
        if (!rst_n) begin
            start_tog <= 1'b0;
        end else if (bus.scl) begin
            start_tog <= ~start_tog;
        end
    end

    always_ff @(posedge bus.sda or negedge rst_n) begin
        if (!rst_n) begin
            stop_tog <= 1'b0;
        end else if (bus.scl) begin
            stop_tog <= ~stop_tog;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link domain, clocked by SCL

    sca_dev_state_type state;
    sca_dev_state_type next_state;
    logic start_seen;
    logic stop_seen;
    logic strap_s1;
    logic strap_s2;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [3:0] sub;
    logic [3:0] next_sub;
    logic inc;
    logic next_inc;
    logic ack_req;
    logic next_ack_req;
    logic wr_tog;
    logic [2:0] wr_idx;
    logic [7:0] wr_val;
    logic sda_oe;
    logic sda_o;

    wire logic start_new = start_tog ^ start_seen;
    wire logic stop_new = stop_tog ^ stop_seen;
    // SDA is only sampled on the rising SCL edge, where it is stable
    wire logic [7:0] rx_byte = {shreg[6:0], bus.sda};
    wire logic byte_end = bit_cnt == SCA_LAST_BIT;
    wire logic ack_slot = bit_cnt == SCA_ACK_SLOT;
    wire logic [7:0] own_addr = strap_s2 ? SCA_ADDR_SUPPLY : SCA_ADDR_OPEN;
    wire logic addr_hit = rx_byte == own_addr;
    wire logic busy = state == ST_ADDR || state == ST_SUB || state == ST_DATA;
    wire logic in_frame = !start_new && !stop_new && busy;
    wire logic sub_used = !sub[SCA_SUB_BANK_BIT] && sub[2:0] <= SCA_SUB_LAST_USED;
    wire logic data_wr = in_frame && !ack_slot && byte_end && state == ST_DATA && sub_used;

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_sub = sub;
        next_inc = inc;
        next_ack_req = ack_req;
        if (start_new) begin
            // First data bit is sampled on the first rising edge
            next_state = ST_ADDR;
            next_bit_cnt = SCA_FIRST_BIT_DONE;
            next_shreg = {7'h00, bus.sda};
            next_ack_req = 1'b0;
        end else if (stop_new) begin
            next_state = ST_IDLE;
            next_bit_cnt = 4'h0;
            next_ack_req = 1'b0;
        end else if (!busy) begin
            next_ack_req = 1'b0;
        end else if (ack_slot) begin
            next_bit_cnt = 4'h0;
            next_ack_req = 1'b0;
        end else begin
            next_shreg = rx_byte;
            next_bit_cnt = bit_cnt + 4'h1;
            if (byte_end) begin
                if (state == ST_ADDR) begin
                    next_state = addr_hit ? ST_SUB : ST_IGNORE;
                    next_ack_req = addr_hit;
                end else if (state == ST_SUB) begin
                    next_sub = rx_byte[3:0];
                    next_inc = rx_byte[SCA_SUB_INC_BIT];
                    next_state = ST_DATA;
                    next_ack_req = 1'b1;
                end else begin
                    next_ack_req = 1'b1;
                    // Four-bit wrap loops through the discarded upper half
                    if (inc) begin
                        next_sub = sub + SCA_SUB_STEP;
                    end
                end
            end
        end
    end

    always_ff @(posedge bus.scl or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            start_seen <= 1'b0;
            stop_seen <= 1'b0;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            sub <= 4'h0;
            inc <= 1'b0;
            ack_req <= 1'b0;
        end else begin
            state <= next_state;
            start_seen <= start_tog;
            stop_seen <= stop_tog;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            sub <= next_sub;
            inc <= next_inc;
            ack_req <= next_ack_req;
        end
    end

    // Strap is static; synchronised only to keep it off the async path
    always_ff @(posedge bus.scl or negedge rst_n) begin
        if (!rst_n) begin
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
        end else begin
            strap_s1 <= addr_sel;
            strap_s2 <= strap_s1;
        end
    end

    // Write word held stable for nine SCL periods after the toggle
    always_ff @(posedge bus.scl or negedge rst_n) begin
        if (!rst_n) begin
            wr_tog <= 1'b0;
            wr_idx <= 3'h0;
            wr_val <= 8'h00;
        end else if (data_wr) begin
            wr_tog <= ~wr_tog;
            wr_idx <= sub[2:0];
            wr_val <= rx_byte;
        end
    end

    // Ack driven from the falling edge after the eighth bit to the next one
    always_ff @(negedge bus.scl or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            sda_oe <= ack_slot && ack_req;
            sda_o <= 1'b0;
        end
    end

    assign bus.dev_sda_oe = sda_oe;
    assign bus.dev_sda_o = sda_o;

    ////////////////////////////////////////////////////////////////////////////
    // System domain: toggle crossing and attenuation decode

    logic wr_s1;
    logic wr_s2;
    logic wr_s3;

    wire logic wr_evt = wr_s2 ^ wr_s3;

    function automatic logic [SCA_ATT_W-1:0] att_of(input logic [7:0] v);
        logic [SCA_ATT_W-1:0] coarse;
        coarse = SCA_ATT_MUTE;
        unique case (v[7:6])
            SCA_RANGE_FINE8: coarse = {1'b0, v[5:3], 3'h0};
            SCA_RANGE_64: coarse = SCA_ATT_64;
            SCA_RANGE_72: coarse = SCA_ATT_72;
            SCA_RANGE_MUTE: coarse = SCA_ATT_MUTE;
        endcase
        if (v[7:6] == SCA_RANGE_MUTE) begin
            return SCA_ATT_MUTE;
        end
        return coarse + {4'h0, v[2:0]};
    endfunction : att_of

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_s1 <= 1'b0;
            wr_s2 <= 1'b0;
            wr_s3 <= 1'b0;
            update <= 1'b0;
        end else begin
            wr_s1 <= wr_tog;
            wr_s2 <= wr_s1;
            wr_s3 <= wr_s2;
            update <= wr_evt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_OUT; i++) begin
                att_db[i] <= SCA_ATT_RESET;
                mute[i] <= SCA_MUTE_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_OUT; i++) begin
                if (wr_evt && wr_idx == i[2:0]) begin
                    att_db[i] <= att_of(wr_val);
                    mute[i] <= wr_val[7:6] == SCA_RANGE_MUTE;
                end
            end
        end
    end

endmodule : sca_dev

// [src/sca_pkg.sv]
package sca_pkg;
    // Chip address bytes, selected by the address strap
    localparam logic [7:0] SCA_ADDR_OPEN = 8'h88;
    localparam logic [7:0] SCA_ADDR_SUPPLY = 8'h8A;
    // Byte framing
    localparam logic [3:0] SCA_LAST_BIT = 4'h7;
    localparam logic [3:0] SCA_ACK_SLOT = 4'h8;
    localparam logic [3:0] SCA_FIRST_BIT_DONE = 4'h1;
    // Subaddress fields
    localparam int SCA_SUB_INC_BIT = 4;
    localparam int SCA_SUB_BANK_BIT = 3;
    localparam logic [2:0] SCA_SUB_LAST_USED = 3'h5;
    localparam logic [3:0] SCA_SUB_STEP = 4'h1;
    // Attenuation data fields
    localparam int SCA_NUM_OUT = 6;
    localparam int SCA_ATT_W = 7;
    localparam logic [1:0] SCA_RANGE_FINE8 = 2'h0;
    localparam logic [1:0] SCA_RANGE_64 = 2'h1;
    localparam logic [1:0] SCA_RANGE_72 = 2'h2;
    localparam logic [1:0] SCA_RANGE_MUTE = 2'h3;
    localparam logic [6:0] SCA_ATT_64 = 7'h40;
    localparam logic [6:0] SCA_ATT_72 = 7'h48;
    localparam logic [6:0] SCA_ATT_MUTE = 7'h7F;
    // Outputs come up silent
    localparam logic [6:0] SCA_ATT_RESET = 7'h7F;
    localparam logic SCA_MUTE_RESET = 1'b1;
    // Host bit timing: one quarter of an SCL period
    localparam int SCA_CLK_PERIOD_NS = 50;
    localparam int SCA_SCL_QUARTER_NS = 100;
    localparam int SCA_QTR_CYCLES =
        (SCA_SCL_QUARTER_NS + SCA_CLK_PERIOD_NS - 1) / SCA_CLK_PERIOD_NS;
    localparam int SCA_DIV_W = 8;
    // Host byte kinds
    localparam logic [1:0] SCA_KIND_CHIP = 2'h0;
    localparam logic [1:0] SCA_KIND_SUB = 2'h1;
    localparam logic [1:0] SCA_KIND_DATA = 2'h2;
endpackage : sca_pkg

// [src/sca_bus_if.sv]
`timescale 1ns/1ns
interface sca_bus_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;

    // Open drain with pull-up: any enabled low driver wins
    assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

    modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
    modport dev (input scl, output dev_sda_o, output dev_sda_oe, input sda);
endinterface : sca_bus_if

// [src/sca_host.sv]
`timescale 1ns/1ns
module sca_host
    import sca_pkg::*;
#(
    parameter int QTR_CYCLES = SCA_QTR_CYCLES
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic check_ack,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [7:0] req_chip,
    input wire logic [7:0] req_sub,
    input wire logic byte_valid,
    output logic byte_ready,
    input wire logic [7:0] byte_data,
    input wire logic byte_last,
    output logic done,
    output logic nack_seen,
    sca_bus_if.host bus
);

    typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} sca_host_state_type;

    sca_host_state_type state;
    logic [SCA_DIV_W-1:0] div;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic [7:0] sub_l;
    logic [1:0] kind;
    logic last_sent;
    logic nack;
    logic [7:0] hold;
    logic hold_last;
    logic scl;
    logic sda_oe;
    logic sda_o;
    logic sda_s1;
    logic sda_s2;

    wire logic tick = div == '0;
    wire logic req_take = state == H_IDLE && req_valid && req_ready;
    wire logic byte_take = byte_valid && byte_ready;
    wire logic in_ack = bitn == SCA_ACK_SLOT;
    wire logic byte_fin = state == H_BIT && tick && ph == 2'h3 && in_ack;
    wire logic abort = check_ack && nack;
    wire logic load_hold = byte_fin && !abort && kind != SCA_KIND_CHIP
        && !last_sent && !byte_ready;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div <= '0;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
        end else begin
            div <= tick ? SCA_DIV_W'(QTR_CYCLES - 1) : div - 1'b1;
            sda_s1 <= bus.sda;
            sda_s2 <= sda_s1;
        end
    end

    // One-deep holding register; SCL is held low while it is empty
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold <= 8'h00;
            hold_last <= 1'b0;
            byte_ready <= 1'b1;
        end else if (byte_take) begin
            hold <= byte_data;
            hold_last <= byte_last;
            byte_ready <= 1'b0;
        end else if (load_hold || req_take) begin
            byte_ready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= H_IDLE;
            ph <= 2'h0;
            bitn <= 4'h0;
            shift <= 8'h00;
            sub_l <= 8'h00;
            kind <= SCA_KIND_CHIP;
            last_sent <= 1'b0;
            nack <= 1'b0;
            scl <= 1'b1;
            sda_oe <= 1'b0;
            sda_o <= 1'b0;
            req_ready <= 1'b1;
            done <= 1'b0;
            nack_seen <= 1'b0;
        end else begin
            done <= 1'b0;
            if (req_take) begin
                state <= H_START;
                ph <= 2'h0;
                shift <= req_chip;
                sub_l <= req_sub;
                kind <= SCA_KIND_CHIP;
                last_sent <= 1'b0;
                req_ready <= 1'b0;
                nack_seen <= 1'b0;
            end else if (tick && state == H_START) begin
                if (ph == 2'h0) begin
                    sda_oe <= 1'b1;
                    ph <= 2'h1;
                end else begin
                    scl <= 1'b0;
                    state <= H_BIT;
                    ph <= 2'h0;
                    bitn <= 4'h0;
                end
            end else if (tick && state == H_BIT) begin
                unique case (ph)
                    2'h0: begin
                        // Data changes only while SCL is low
                        sda_oe <= !in_ack && !shift[7];
                        ph <= 2'h1;
                    end
                    2'h1: begin
                        scl <= 1'b1;
                        ph <= 2'h2;
                    end
                    2'h2: begin
                        nack <= in_ack && sda_s2;
                        ph <= 2'h3;
                    end
                    2'h3: begin
                        scl <= 1'b0;
                        if (!in_ack) begin
                            shift <= {shift[6:0], 1'b0};
                            bitn <= bitn + 4'h1;
                            ph <= 2'h0;
                        end else if (abort) begin
                            nack_seen <= 1'b1;
                            state <= H_STOP;
                            ph <= 2'h0;
                        end else if (kind == SCA_KIND_CHIP) begin
                            shift <= sub_l;
                            kind <= SCA_KIND_SUB;
                            bitn <= 4'h0;
                            ph <= 2'h0;
                        end else if (last_sent) begin
                            state <= H_STOP;
                            ph <= 2'h0;
                        end else if (load_hold) begin
                            shift <= hold;
                            last_sent <= hold_last;
                            kind <= SCA_KIND_DATA;
                            bitn <= 4'h0;
                            ph <= 2'h0;
                        end
                    end
                endcase
            end else if (tick && state == H_STOP) begin
                unique case (ph)
                    2'h0: sda_oe <= 1'b1;
                    2'h1: scl <= 1'b1;
                    2'h2: sda_oe <= 1'b0;
                    2'h3: begin
                        state <= H_IDLE;
                        done <= 1'b1;
                        req_ready <= 1'b1;
                    end
                endcase
                ph <= ph + 2'h1;
            end
        end
    end

    assign bus.scl = scl;
    assign bus.host_sda_oe = sda_oe;
    assign bus.host_sda_o = sda_o;

endmodule : sca_host

// [tb/sca_chk.sv]
`timescale 1ns/1ns
module sca_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe,
    input wire logic sda
);
    ////////////////////////////////////////////////////////////////////////////////
    // Bit position tracker, restarted by every start condition
    logic sda_q;
    logic scl_q;
    logic [3:0] bit_cnt;
    wire start_seen = scl && scl_q && sda_q && !sda;
    wire scl_rise = scl && !scl_q;
    wire [3:0] next_bit_cnt = (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_q <= 1'b1;
            scl_q <= 1'b1;
            bit_cnt <= 4'h0;
        end else begin
            sda_q <= sda;
            scl_q <= scl;
            if (start_seen) begin
                bit_cnt <= 4'h0;
            end else if (scl_rise) begin
                bit_cnt <= next_bit_cnt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // SCL comes from a host flop, so the system clock sees every phase
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    dev_change_a: assert property (
        $changed(dev_sda_oe) |-> !scl) else $error("device moved SDA while SCL high");
    host_stable_a: assert property (
        scl_rise |-> $stable(host_sda_oe) [*2]) else $error("host moved SDA in a bit");
    start_form_a: assert property (
        $rose(host_sda_oe) && scl |-> ##[1:4] !scl) else $error("start not followed by SCL low");
    stop_form_a: assert property (
        $fell(host_sda_oe) && scl |-> sda ##1 (sda && scl)) else $error("stop not held idle");
    ack_slot_a: assert property (
        scl_rise && dev_sda_oe |-> bit_cnt == 4'h8) else $error("ack outside ninth clock");
    ack_hold_a: assert property (
        scl_rise && dev_sda_oe |-> (dev_sda_oe && !sda) [*3]) else $error("ack dropped early");
    host_release_a: assert property (
        scl_rise && bit_cnt == 4'h8 |-> !host_sda_oe) else $error("host drove SDA in ack");
    ack_release_a: assert property (
        $rose(dev_sda_oe) |-> ##[4:16] $fell(dev_sda_oe)) else $error("ack never released");
endmodule : sca_chk

// [tb/tb.sv]
`timescale 1ns/1ns
module tb
    import sca_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic addr_sel = 1'b0;
    logic check_ack = 1'b0;
    logic req_valid = 1'b0;
    logic [7:0] req_chip = 8'h00;
    logic [7:0] req_sub = 8'h00;
    logic byte_valid = 1'b0;
    logic [7:0] byte_data = 8'h00;
    logic byte_last = 1'b0;
    logic req_ready;
    logic byte_ready;
    logic done;
    logic nack_seen;
    logic update;
    logic [SCA_NUM_OUT-1:0][SCA_ATT_W-1:0] att_db;
    logic [SCA_NUM_OUT-1:0] mute;
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    int upd_cnt = 0;
    logic [7:0] exp_out [0:5];
    logic [7:0] dq [0:15];

    ////////////////////////////////////////////////////////////////////////////////
    always #25 clk = ~clk;

    sca_bus_if sca_bus_if_inst ();

    sca_dev sca_dev_inst (.clk(clk), .rst_n(rst_n), .addr_sel(addr_sel),
        .bus(sca_bus_if_inst), .att_db(att_db), .mute(mute), .update(update));

    sca_host sca_host_inst (.clk(clk), .rst_n(rst_n), .check_ack(check_ack),
        .req_valid(req_valid), .req_ready(req_ready), .req_chip(req_chip),
        .req_sub(req_sub), .byte_valid(byte_valid), .byte_ready(byte_ready),
        .byte_data(byte_data), .byte_last(byte_last), .done(done),
        .nack_seen(nack_seen), .bus(sca_bus_if_inst));

    sca_chk sca_chk_inst (.clk(clk), .rst_n(rst_n), .scl(sca_bus_if_inst.scl),
        .host_sda_oe(sca_bus_if_inst.host_sda_oe), .dev_sda_oe(sca_bus_if_inst.dev_sda_oe),
        .sda(sca_bus_if_inst.sda));

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (update === 1'b1) upd_cnt++;
        // Frames take at most about 670 cycles each; ceiling leaves wide margin
        if (cycles == 60000) begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Expected {mute, level} for one data byte
    function automatic logic [7:0] dec(input logic [7:0] d);
        case (d[7:6])
            2'h0: return {2'h0, d[5:0]};
            2'h1: return {1'b0, 4'h8, d[2:0]};
            2'h2: return {1'b0, 4'h9, d[2:0]};
            default: return {1'b1, 7'h7F};
        endcase
    endfunction : dec

    ////////////////////////////////////////////////////////////////////////////////
    // One whole frame, model update, then compare every output
    task automatic frame(input logic [7:0] chip, input logic [7:0] sub, input int n);
        logic [3:0] p;
        logic hit;
        int m;
        int nup;
        int i;
        @(posedge clk);
        p = sub[3:0];
        hit = (chip === (addr_sel ? SCA_ADDR_SUPPLY : SCA_ADDR_OPEN));
        // Aborted frames never ask for a second byte
        m = (check_ack && !hit) ? 1 : n;
        nup = upd_cnt;
        req_chip <= chip;
        req_sub <= sub;
        req_valid <= 1'b1;
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        for (i = 0; i < m; i++) begin
            byte_data <= dq[i];
            byte_last <= (i == m - 1);
            byte_valid <= 1'b1;
            do @(posedge clk); while (byte_ready !== 1'b1);
            if (hit && p < 4'h6) begin
                exp_out[p] = dec(dq[i]);
                nup++;
            end
            if (sub[SCA_SUB_INC_BIT]) p = p + SCA_SUB_STEP;
        end
        byte_valid <= 1'b0;
        do @(posedge clk); while (done !== 1'b1);
        repeat (4) @(posedge clk);
        for (i = 0; i < SCA_NUM_OUT; i++) begin
            chk("output", 32'(exp_out[i]), 32'({mute[i], att_db[i]}));
        end
        chk("updates", 32'(nup), 32'(upd_cnt));
        chk("nack", 32'(check_ack && !hit), 32'(nack_seen));
    endtask : frame

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int k;
        int j;
        logic [7:0] ch;
        for (k = 0; k < SCA_NUM_OUT; k++) exp_out[k] = {SCA_MUTE_RESET, SCA_ATT_RESET};
        void'($urandom(15592));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (k = 0; k < SCA_NUM_OUT; k++) begin
            chk("reset", 32'(exp_out[k]), 32'({mute[k], att_db[k]}));
        end
        // Every range code and every coarse and fine step, single location
        for (k = 0; k < 12; k++) begin
            dq[0] = 8'($urandom);
            dq[1] = (k < 8) ? {2'h0, 3'(k), 3'(7 - k)} : {2'(k - 8), 6'($urandom)};
            frame(SCA_ADDR_OPEN, {3'($urandom), 1'b0, 4'(k % 6)}, 2);
        end
        frame(SCA_ADDR_OPEN, 8'hE7, 1);
        for (j = 0; j < 16; j++) dq[j] = 8'($urandom);
        frame(SCA_ADDR_OPEN, 8'hB2, 7);
        frame(SCA_ADDR_OPEN, 8'h1D, 6);
        addr_sel <= 1'b1;
        frame(SCA_ADDR_SUPPLY, 8'h10, 6);
        frame(SCA_ADDR_OPEN, 8'h10, 3);
        check_ack <= 1'b1;
        frame(SCA_ADDR_OPEN, 8'h01, 1);
        frame(SCA_ADDR_SUPPLY, 8'h03, 2);
        // Random frames with either strap and either ack policy
        for (k = 0; k < 12; k++) begin
            for (j = 0; j < 16; j++) dq[j] = 8'($urandom);
            ch = ($urandom % 2) ? SCA_ADDR_SUPPLY : SCA_ADDR_OPEN;
            addr_sel <= 1'($urandom);
            check_ack <= 1'($urandom);
            frame(ch, 8'($urandom), 1 + int'($urandom % 6));
        end
        give_verdict();
    end
endmodule : tb
